// >>> hw/mir_pkg.sv
// Purpose: constants for the interrupt routing and flag block
// Assumes: 8-bit special-register bus plus 16-bit external-data register bus
// Notes:   sources are indexed in polling order throughout
package mir_pkg;
    localparam int NSRC = 11;
    // special-register offsets
    localparam logic [7:0] OFS_TIMER_AND_EXT_IRQ_CONTROL_CTRL  = 8'h88;
    localparam logic [7:0] OFS_ENABLE_3RD = 8'h9a;
    localparam logic [7:0] OFS_ENABLE_1ST = 8'ha8;
    localparam logic [7:0] OFS_PRIO_LOW   = 8'ha9;
    localparam logic [7:0] OFS_ENABLE_2ND = 8'hb8;
    localparam logic [7:0] OFS_PRIO_HIGH  = 8'hb9;
    localparam logic [7:0] OFS_REQ_FLAGS  = 8'hc0;
    localparam logic [7:0] OFS_T2_CTRL    = 8'hc8;
    localparam logic [7:0] OFS_SUB_FLAGS  = 8'he8;
    // external-data offsets
    localparam logic [15:0] OFS_XFER_TICK_EN = 16'h2002;
    localparam logic [15:0] OFS_COL_PLL_EN   = 16'h2007;
    localparam logic [15:0] OFS_WD_SPI_EN    = 16'h20b0;
    localparam logic [15:0] OFS_WD_SPI_FLAG  = 16'h20b1;
    localparam logic [7:0]  REG_RESET        = 8'h00;
    // idle level of each routed line; history seeded here so reset fakes no edge
    localparam logic [6:0]  LINE_IDLE        = 7'h27;
    // source index in polling order
    localparam int SRC_EXT0 = 0;
    localparam int SRC_SER1 = 1;
    localparam int SRC_TMR0 = 2;
    localparam int SRC_EXT2 = 3;
    localparam int SRC_EXT1 = 4;
    localparam int SRC_EXT3 = 5;
    localparam int SRC_TMR1 = 6;
    localparam int SRC_EXT4 = 7;
    localparam int SRC_SER0 = 8;
    localparam int SRC_EXT5 = 9;
    localparam int SRC_EXT6 = 10;
    // bit positions
    localparam int B_TF1 = 7;
    localparam int B_TF0 = 5;
    localparam int B_IE1 = 3;
    localparam int B_IT1 = 2;
    localparam int B_IE0 = 1;
    localparam int B_IT0 = 0;
    localparam int B_EAL = 7;
    localparam int B_ES0 = 4;
    localparam int B_ET1 = 3;
    localparam int B_EX1 = 2;
    localparam int B_ET0 = 1;
    localparam int B_EX0 = 0;
    localparam int B_ES1 = 0;
    localparam int B_POL3 = 6;
    localparam int B_POL2 = 5;
    localparam int B_SF_XFER  = 0;
    localparam int B_SF_TICK  = 1;
    localparam int B_SF_COL1  = 2;
    localparam int B_SF_COL0  = 3;
    localparam int B_SF_PB    = 4;
    localparam int B_SF_WAKE  = 5;
    localparam int B_SF_PLLR  = 6;
    localparam int B_SF_PLLF  = 7;
    localparam int B_EN_XFER  = 0;
    localparam int B_EN_TICK  = 1;
    localparam int B_EN_COL   = 4;
    localparam int B_EN_PLL   = 5;
    localparam int B_WD       = 0;
    localparam int B_SPI      = 4;
    // used bits of partial registers
    localparam logic [7:0] MASK_TIMER_AND_EXT_IRQ_CONTROL  = 8'hff;
    localparam logic [7:0] MASK_ENABLE_REG_FIRST  = 8'hdf;
    localparam logic [7:0] MASK_ENABLE_REG_SECOND  = 8'h3e;
    localparam logic [7:0] MASK_ENABLE_REG_THIRD  = 8'h01;
    localparam logic [7:0] MASK_PRIO  = 8'h3f;
    localparam logic [7:0] MASK_T2    = 8'h60;
    localparam logic [7:0] MASK_EXT_IRQ_REQUEST_FLAGS = 8'h3e;
    localparam logic [7:0] MASK_WDSPI = 8'h11;
    // priority group and vector of each source, polling order
    localparam logic [2:0]  SRC_GROUP [NSRC] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2,
                                                 3'h3, 3'h3, 3'h4, 3'h4, 3'h5};
    localparam logic [15:0] SRC_VECTOR [NSRC] = '{16'h0003, 16'h0083, 16'h000b, 16'h004b,
                                                  16'h0013, 16'h0053, 16'h001b, 16'h005b,
                                                  16'h0023, 16'h0063, 16'h006b};
endpackage

// >>> hw/mir_irq.sv
// Purpose: interrupt enables, flags, routing and priority choice beside the core
// Assumes: all inputs synchronous to MCLK; event inputs are one-cycle pulses
// Notes:   register reads answer one cycle after the address is presented
`timescale 1ns/100ps
module mir_irq
    import mir_pkg::*;
(
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    // special-register port
    input  wire logic [7:0]  SFR_ADDR,
    input  wire logic        SFR_WE,
    input  wire logic [7:0]  SFR_WDATA,
    output logic      [7:0]  SFR_RDATA,
    // external-data register port
    input  wire logic [15:0] XD_ADDR,
    input  wire logic        XD_WE,
    input  wire logic [7:0]  XD_WDATA,
    output logic      [7:0]  XD_RDATA,
    // interrupt sources
    input  wire logic        DIO_HIGH_N,
    input  wire logic        DIO_LOW_N,
    input  wire logic        TMR0_OVF,
    input  wire logic        TMR1_OVF,
    input  wire logic        SER0_REQ,
    input  wire logic        SER1_REQ,
    input  wire logic        CE_BUSY,
    input  wire logic        EEPROM_BUSY,
    input  wire logic        PLL_LOCKED,
    input  wire logic        TRANSFER_BUSY,
    input  wire logic        ONE_SECOND_TICK,
    input  wire logic        WATCHDOG_NEAR_OVERFLOW,
    input  wire logic        FLASH_COLLISION_0,
    input  wire logic        FLASH_COLLISION_1,
    input  wire logic        SPI_EVENT,
    input  wire logic        TIMED_WAKEUP,
    input  wire logic        PUSH_BUTTON,
    // core side
    input  wire logic [NSRC-1:0] ISR_ACK,
    output logic             IRQ_VALID,
    output logic      [3:0]  IRQ_INDEX,
    output logic      [1:0]  IRQ_LEVEL,
    output logic      [15:0] IRQ_VECTOR
);
    import mir_pkg::*;

    logic [7:0]  timer_and_ext_irq_control_r, enable_reg_first_r, enable_reg_second_r, enable_reg_third_r, ip0_r, ip1_r, ext_irq_polarity_control_r, ext_irq_request_flags_r;
    logic [7:0]  sub_flag_r, xfer_tick_en_r, col_pll_en_r, wd_spi_en_r, wd_spi_flag_r;
    logic [6:0]  line_prev_r;
    logic        pll_prev_r;
    logic [6:0]  line;
    logic [6:0]  ext_set;
    logic [7:0]  sub_set;
    logic [7:0]  wd_spi_set;
    logic [NSRC-1:0] req;
    logic        sfr_wr_timer_and_ext_irq_control, sfr_wr_ext_irq_request_flags, sfr_wr_sub, xd_wr_wdspi;

    function automatic logic [7:0] rd_sfr(input logic [7:0] a, input logic [7:0] tc, input logic [7:0] e0,
                                          input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] p0,
                                          input logic [7:0] p1, input logic [7:0] rc, input logic [7:0] t2,
                                          input logic [7:0] sf);
        unique case (a)
            OFS_TIMER_AND_EXT_IRQ_CONTROL_CTRL:  rd_sfr = tc;
            OFS_ENABLE_1ST: rd_sfr = e0;
            OFS_ENABLE_2ND: rd_sfr = e1;
            OFS_ENABLE_3RD: rd_sfr = e2;
            OFS_PRIO_LOW:   rd_sfr = p0;
            OFS_PRIO_HIGH:  rd_sfr = p1;
            OFS_REQ_FLAGS:  rd_sfr = rc;
            OFS_T2_CTRL:    rd_sfr = t2;
            OFS_SUB_FLAGS:  rd_sfr = sf;
            default:        rd_sfr = 8'h00;
        endcase
    endfunction

    // write-zero-to-clear; ones written are ignored, hardware set wins
    function automatic logic [7:0] w0c(input logic [7:0] cur, input logic we, input logic [7:0] wd,
                                       input logic [7:0] set);
        w0c = (we ? (cur & wd) : cur) | set;
    endfunction

    assign sfr_wr_timer_and_ext_irq_control  = SFR_WE && SFR_ADDR == OFS_TIMER_AND_EXT_IRQ_CONTROL_CTRL;
    assign sfr_wr_ext_irq_request_flags = SFR_WE && SFR_ADDR == OFS_REQ_FLAGS;
    assign sfr_wr_sub   = SFR_WE && SFR_ADDR == OFS_SUB_FLAGS;
    assign xd_wr_wdspi  = XD_WE && XD_ADDR == OFS_WD_SPI_FLAG;

    // sub-source flag setting, independent of enables
    always_comb begin
        sub_set = 8'h00;
        sub_set[B_SF_XFER] = TRANSFER_BUSY;
        sub_set[B_SF_TICK] = ONE_SECOND_TICK;
        sub_set[B_SF_COL1] = FLASH_COLLISION_1;
        sub_set[B_SF_COL0] = FLASH_COLLISION_0;
        sub_set[B_SF_PB]   = PUSH_BUTTON;
        sub_set[B_SF_WAKE] = TIMED_WAKEUP;
        sub_set[B_SF_PLLR] = PLL_LOCKED & ~pll_prev_r;
        sub_set[B_SF_PLLF] = ~PLL_LOCKED & pll_prev_r;
        wd_spi_set = 8'h00;
        wd_spi_set[B_WD]  = WATCHDOG_NEAR_OVERFLOW;
        wd_spi_set[B_SPI] = SPI_EVENT;
    end

    // routed lines; wake and button flags feed no line
    always_comb begin
        line[0] = DIO_HIGH_N;
        line[1] = DIO_LOW_N;
        line[2] = ~(((sub_flag_r[B_SF_COL0] | sub_flag_r[B_SF_COL1]) & col_pll_en_r[B_EN_COL])
                  | (wd_spi_flag_r[B_SPI] & wd_spi_en_r[B_SPI]));
        line[3] = CE_BUSY;
        line[4] = (sub_flag_r[B_SF_PLLR] | sub_flag_r[B_SF_PLLF]) & col_pll_en_r[B_EN_PLL];
        line[5] = ~EEPROM_BUSY;
        line[6] = ~(~((sub_flag_r[B_SF_XFER] & xfer_tick_en_r[B_EN_XFER])
                    | (sub_flag_r[B_SF_TICK] & xfer_tick_en_r[B_EN_TICK])
                    | (wd_spi_flag_r[B_WD] & wd_spi_en_r[B_WD])));
    end

    // edge and level detection per external line
    always_comb begin
        ext_set[0] = timer_and_ext_irq_control_r[B_IT0] ? (line_prev_r[0] & ~line[0]) : ~line[0];
        ext_set[1] = timer_and_ext_irq_control_r[B_IT1] ? (line_prev_r[1] & ~line[1]) : ~line[1];
        ext_set[2] = ext_irq_polarity_control_r[B_POL2] ? (~line_prev_r[2] & line[2]) : (line_prev_r[2] & ~line[2]);
        ext_set[3] = ext_irq_polarity_control_r[B_POL3] ? (~line_prev_r[3] & line[3]) : (line_prev_r[3] & ~line[3]);
        ext_set[4] = ~line_prev_r[4] & line[4];
        ext_set[5] = ~line_prev_r[5] & line[5];
        ext_set[6] = ~line_prev_r[6] & line[6];
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            line_prev_r <= LINE_IDLE;
            pll_prev_r  <= 1'b0;
        end else begin
            line_prev_r <= line;
            pll_prev_r  <= PLL_LOCKED;
        end
    end

    // control registers
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            enable_reg_first_r  <= REG_RESET;
            enable_reg_second_r  <= REG_RESET;
            enable_reg_third_r  <= REG_RESET;
            ip0_r   <= REG_RESET;
            ip1_r   <= REG_RESET;
            ext_irq_polarity_control_r <= REG_RESET;
        end else if (SFR_WE) begin
            if (SFR_ADDR == OFS_ENABLE_1ST) enable_reg_first_r <= SFR_WDATA & MASK_ENABLE_REG_FIRST;
            if (SFR_ADDR == OFS_ENABLE_2ND) enable_reg_second_r <= SFR_WDATA & MASK_ENABLE_REG_SECOND;
            if (SFR_ADDR == OFS_ENABLE_3RD) enable_reg_third_r <= SFR_WDATA & MASK_ENABLE_REG_THIRD;
            if (SFR_ADDR == OFS_PRIO_LOW)   ip0_r  <= SFR_WDATA & MASK_PRIO;
            if (SFR_ADDR == OFS_PRIO_HIGH)  ip1_r  <= SFR_WDATA & MASK_PRIO;
            if (SFR_ADDR == OFS_T2_CTRL)    ext_irq_polarity_control_r <= SFR_WDATA & MASK_T2;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            xfer_tick_en_r <= REG_RESET;
            col_pll_en_r   <= REG_RESET;
            wd_spi_en_r    <= REG_RESET;
        end else if (XD_WE) begin
            if (XD_ADDR == OFS_XFER_TICK_EN) xfer_tick_en_r <= XD_WDATA;
            if (XD_ADDR == OFS_COL_PLL_EN)   col_pll_en_r   <= XD_WDATA;
            if (XD_ADDR == OFS_WD_SPI_EN)    wd_spi_en_r    <= XD_WDATA & MASK_WDSPI;
        end
    end

    // main flags: software may write, vectoring clears, hardware set wins
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            timer_and_ext_irq_control_r  <= REG_RESET;
            ext_irq_request_flags_r <= REG_RESET;
        end else begin
            timer_and_ext_irq_control_r <= sfr_wr_timer_and_ext_irq_control ? (SFR_WDATA & MASK_TIMER_AND_EXT_IRQ_CONTROL) : timer_and_ext_irq_control_r;
            timer_and_ext_irq_control_r[B_TF0] <= ((sfr_wr_timer_and_ext_irq_control ? SFR_WDATA[B_TF0] : timer_and_ext_irq_control_r[B_TF0]) & ~ISR_ACK[SRC_TMR0])
                             | TMR0_OVF;
            timer_and_ext_irq_control_r[B_TF1] <= ((sfr_wr_timer_and_ext_irq_control ? SFR_WDATA[B_TF1] : timer_and_ext_irq_control_r[B_TF1]) & ~ISR_ACK[SRC_TMR1])
                             | TMR1_OVF;
            timer_and_ext_irq_control_r[B_IE0] <= ((sfr_wr_timer_and_ext_irq_control ? SFR_WDATA[B_IE0] : timer_and_ext_irq_control_r[B_IE0]) & ~ISR_ACK[SRC_EXT0])
                             | ext_set[0];
            timer_and_ext_irq_control_r[B_IE1] <= ((sfr_wr_timer_and_ext_irq_control ? SFR_WDATA[B_IE1] : timer_and_ext_irq_control_r[B_IE1]) & ~ISR_ACK[SRC_EXT1])
                             | ext_set[1];
            ext_irq_request_flags_r <= (((sfr_wr_ext_irq_request_flags ? SFR_WDATA : ext_irq_request_flags_r)
                        & ~{2'b00, ISR_ACK[SRC_EXT6], ISR_ACK[SRC_EXT5], ISR_ACK[SRC_EXT4],
                            ISR_ACK[SRC_EXT3], ISR_ACK[SRC_EXT2], 1'b0})
                        | {2'b00, ext_set[6:2], 1'b0}) & MASK_EXT_IRQ_REQUEST_FLAGS;
        end
    end

    // sub-source flags; a bit operation here can lose a flag set mid-macro
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            sub_flag_r    <= REG_RESET;
            wd_spi_flag_r <= REG_RESET;
        end else begin
            sub_flag_r    <= w0c(sub_flag_r, sfr_wr_sub, SFR_WDATA, sub_set);
            wd_spi_flag_r <= w0c(wd_spi_flag_r, xd_wr_wdspi, XD_WDATA, wd_spi_set) & MASK_WDSPI;
        end
    end

    // gated requests in polling order
    always_comb begin
        req[SRC_EXT0] = timer_and_ext_irq_control_r[B_IE0] & enable_reg_first_r[B_EX0];
        req[SRC_SER1] = SER1_REQ & enable_reg_third_r[B_ES1];
        req[SRC_TMR0] = timer_and_ext_irq_control_r[B_TF0] & enable_reg_first_r[B_ET0];
        req[SRC_EXT2] = ext_irq_request_flags_r[1] & enable_reg_second_r[1];
        req[SRC_EXT1] = timer_and_ext_irq_control_r[B_IE1] & enable_reg_first_r[B_EX1];
        req[SRC_EXT3] = ext_irq_request_flags_r[2] & enable_reg_second_r[2];
        req[SRC_TMR1] = timer_and_ext_irq_control_r[B_TF1] & enable_reg_first_r[B_ET1];
        req[SRC_EXT4] = ext_irq_request_flags_r[3] & enable_reg_second_r[3];
        req[SRC_SER0] = SER0_REQ & enable_reg_first_r[B_ES0];
        req[SRC_EXT5] = ext_irq_request_flags_r[4] & enable_reg_second_r[4];
        req[SRC_EXT6] = ext_irq_request_flags_r[5] & enable_reg_second_r[5];
        req = req & {NSRC{enable_reg_first_r[B_EAL]}};
    end

    // choose highest level, then first in polling order; registered for timing
    always_ff @(posedge MCLK) begin
        logic       found;
        logic [1:0] lvl;
        logic [1:0] best_lvl;
        logic [3:0] best;
        found = 1'b0;
        lvl = 2'd0;
        best_lvl = 2'd0;
        best = 4'd0;
        for (int i = 0; i < NSRC; i++) begin
            lvl = {ip1_r[SRC_GROUP[i]], ip0_r[SRC_GROUP[i]]};
            if (req[i] && (!found || lvl > best_lvl)) begin
                found = 1'b1;
                best_lvl = lvl;
                best = 4'(i);
            end
        end
        if (SYS_RST) begin
            IRQ_VALID  <= 1'b0;
            IRQ_INDEX  <= 4'h0;
            IRQ_LEVEL  <= 2'h0;
            IRQ_VECTOR <= 16'h0000;
        end else begin
            IRQ_VALID  <= found & ~|ISR_ACK;
            IRQ_INDEX  <= best;
            IRQ_LEVEL  <= best_lvl;
            IRQ_VECTOR <= SRC_VECTOR[best];
        end
    end

    // read data
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            SFR_RDATA <= 8'h00;
            XD_RDATA  <= 8'h00;
        end else begin
            SFR_RDATA <= rd_sfr(SFR_ADDR, timer_and_ext_irq_control_r, enable_reg_first_r, enable_reg_second_r, enable_reg_third_r, ip0_r, ip1_r,
                                ext_irq_request_flags_r, ext_irq_polarity_control_r, sub_flag_r);
            unique case (XD_ADDR)
                OFS_XFER_TICK_EN: XD_RDATA <= xfer_tick_en_r;
                OFS_COL_PLL_EN:   XD_RDATA <= col_pll_en_r;
                OFS_WD_SPI_EN:    XD_RDATA <= wd_spi_en_r;
                OFS_WD_SPI_FLAG:  XD_RDATA <= wd_spi_flag_r;
                default:          XD_RDATA <= 8'h00;
            endcase
        end
    end
endmodule

// >>> verification/mir_irq_checker.sv
// Purpose: port checks on delivery, masking and register timing
// Assumes: enables and priorities mirrored from the special-register port
// Notes:   mirrors lag one edge to line up with the registered request
`timescale 1ns/100ps
module mir_irq_checker
    import mir_pkg::*;
(
    // clock and reset
    input wire logic            MCLK,
    input wire logic            SYS_RST,
    // register port
    input wire logic [7:0]      SFR_ADDR,
    input wire logic            SFR_WE,
    input wire logic [7:0]      SFR_WDATA,
    input wire logic [7:0]      SFR_RDATA,
    // sources and core side
    input wire logic            TMR0_OVF,
    input wire logic            SER1_REQ,
    input wire logic [NSRC-1:0] ISR_ACK,
    input wire logic            IRQ_VALID,
    input wire logic [3:0]      IRQ_INDEX,
    input wire logic [1:0]      IRQ_LEVEL,
    input wire logic [15:0]     IRQ_VECTOR
);
    logic [7:0]      e0_r, e1_r, e2_r, p0_r, p1_r, e0_q, e1_q, e2_q, p0_q, p1_q;
    logic [NSRC-1:0] en_q;
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            {e0_r, e1_r, e2_r, p0_r, p1_r} <= '0;
        end else if (SFR_WE) begin
            if (SFR_ADDR == OFS_ENABLE_1ST) e0_r <= SFR_WDATA;
            if (SFR_ADDR == OFS_ENABLE_2ND) e1_r <= SFR_WDATA;
            if (SFR_ADDR == OFS_ENABLE_3RD) e2_r <= SFR_WDATA;
            if (SFR_ADDR == OFS_PRIO_LOW) p0_r <= SFR_WDATA;
            if (SFR_ADDR == OFS_PRIO_HIGH) p1_r <= SFR_WDATA;
        end
    end
    // second stage: the request register samples what the first stage held
    always_ff @(posedge MCLK) begin
        {e0_q, e1_q, e2_q, p0_q, p1_q} <= SYS_RST ? '0 : {e0_r, e1_r, e2_r, p0_r, p1_r};
    end
    assign en_q = {e1_q[5], e1_q[4], e0_q[4], e1_q[3], e0_q[3], e1_q[2], e0_q[2], e1_q[1], e0_q[1], e2_q[0], e0_q[0]};
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    sequence hold_quiet;
        ISR_ACK == '0 && !SFR_WE && e0_q[B_EAL] && e0_q[B_ET0];
    endsequence
    sequence ser1_live;
        SER1_REQ && ISR_ACK == '0 && e0_q[B_EAL] && e2_q[B_ES1];
    endsequence
    ack_quiet_a: assert property (ISR_ACK != '0 |=> !IRQ_VALID)
        else $error("request held after acknowledge");
    global_off_a: assert property (!e0_q[B_EAL] |-> !IRQ_VALID)
        else $error("request with global enable off");
    src_enabled_a: assert property (IRQ_VALID |-> en_q[IRQ_INDEX])
        else $error("request from a disabled source");
    vector_map_a: assert property (IRQ_VALID |-> IRQ_INDEX < 4'hb && IRQ_VECTOR == SRC_VECTOR[IRQ_INDEX])
        else $error("wrong vector for source");
    group_level_a: assert property (IRQ_VALID |->
        IRQ_LEVEL == {p1_q[SRC_GROUP[IRQ_INDEX]], p0_q[SRC_GROUP[IRQ_INDEX]]})
        else $error("wrong priority level");
    timer_latency_a: assert property (TMR0_OVF ##0 hold_quiet ##1 hold_quiet |=> IRQ_VALID)
        else $error("timer request late");
    serial_level_a: assert property (ser1_live [*3] |-> IRQ_VALID)
        else $error("serial request not presented");
    polarity_read_a: assert property (SFR_WE && SFR_ADDR == OFS_T2_CTRL ##1 !SFR_WE && SFR_ADDR == OFS_T2_CTRL
        |=> SFR_RDATA == ($past(SFR_WDATA, 2) & MASK_T2))
        else $error("polarity register readback wrong");
endmodule
bind mir_irq mir_irq_checker i_chk (.MCLK, .SYS_RST, .SFR_ADDR, .SFR_WE, .SFR_WDATA, .SFR_RDATA, .TMR0_OVF,
    .SER1_REQ, .ISR_ACK, .IRQ_VALID, .IRQ_INDEX, .IRQ_LEVEL, .IRQ_VECTOR);

// >>> verification/mir_core_model.sv
// Purpose: stand-in for the core's acknowledge on vectoring
// Assumes: one acknowledge per presented request
// Notes:   arm low models a core holding interrupts off
`timescale 1ns/100ps
module mir_core_model
    import mir_pkg::*;
(
    // clock and reset
    input  wire logic [0:0]      mclk,
    input  wire logic            sys_rst,
    // bench control
    input  wire logic            arm,
    input  wire logic [3:0]      delay,
    // interrupt side
    input  wire logic            irq_valid,
    input  wire logic [3:0]      irq_index,
    output logic      [NSRC-1:0] isr_ack
);
    logic [3:0] wait_r;
    // single-cycle ack; a held one would eat a flag set again meanwhile
    always_ff @(posedge mclk) begin
        isr_ack <= '0;
        if (sys_rst || !arm || !irq_valid || isr_ack != '0) begin
            wait_r <= 4'h0;
        end else if (wait_r == delay) begin
            isr_ack[irq_index] <= 1'b1;
            wait_r <= 4'h0;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule

// >>> verification/mir_irq_tb_top.sv
// Purpose: directed register, flag and delivery tests
// Assumes: core stand-in acknowledges only while armed
// Notes:   inputs move 1 ns after the rising edge
`timescale 1ns/100ps
module mir_irq_tb_top
    import mir_pkg::*;
;
    logic            MCLK, SYS_RST, SFR_WE, XD_WE, IRQ_VALID, arm;
    logic            DIO_HIGH_N, DIO_LOW_N, TMR0_OVF, TMR1_OVF, SER0_REQ, SER1_REQ, CE_BUSY, EEPROM_BUSY, PLL_LOCKED;
    logic [7:0]      SFR_ADDR, SFR_WDATA, SFR_RDATA, XD_WDATA, XD_RDATA, sev;
    logic [15:0]     XD_ADDR, IRQ_VECTOR;
    logic [NSRC-1:0] ISR_ACK;
    logic [3:0]      IRQ_INDEX, dly;
    logic [1:0]      IRQ_LEVEL;
    int              mismatches, n_checks, i;
    logic [7:0]      ra [8] = '{OFS_TIMER_AND_EXT_IRQ_CONTROL_CTRL, OFS_ENABLE_3RD, OFS_ENABLE_1ST, OFS_PRIO_LOW, OFS_ENABLE_2ND,
                                OFS_PRIO_HIGH, OFS_REQ_FLAGS, OFS_T2_CTRL};
    logic [7:0]      rm [8] = '{MASK_TIMER_AND_EXT_IRQ_CONTROL, MASK_ENABLE_REG_THIRD, MASK_ENABLE_REG_FIRST, MASK_PRIO, MASK_ENABLE_REG_SECOND, MASK_PRIO, MASK_EXT_IRQ_REQUEST_FLAGS, MASK_T2};
    logic [15:0]     xa [4] = '{OFS_XFER_TICK_EN, OFS_COL_PLL_EN, OFS_WD_SPI_EN, OFS_WD_SPI_FLAG};
    logic [7:0]      xm [4] = '{8'hff, 8'hff, MASK_WDSPI, 8'h00};
    initial MCLK = 1'b0;
    always #4 MCLK = ~MCLK;
    mir_irq i_dut (.MCLK, .SYS_RST, .SFR_ADDR, .SFR_WE, .SFR_WDATA, .SFR_RDATA, .XD_ADDR, .XD_WE, .XD_WDATA,
        .XD_RDATA, .DIO_HIGH_N, .DIO_LOW_N, .TMR0_OVF, .TMR1_OVF, .SER0_REQ, .SER1_REQ, .CE_BUSY, .EEPROM_BUSY,
        .PLL_LOCKED, .TRANSFER_BUSY(sev[0]), .ONE_SECOND_TICK(sev[1]), .WATCHDOG_NEAR_OVERFLOW(sev[6]),
        .FLASH_COLLISION_0(sev[3]), .FLASH_COLLISION_1(sev[2]), .SPI_EVENT(sev[7]), .TIMED_WAKEUP(sev[5]),
        .PUSH_BUTTON(sev[4]), .ISR_ACK, .IRQ_VALID, .IRQ_INDEX, .IRQ_LEVEL, .IRQ_VECTOR);
    mir_core_model i_core (.mclk(MCLK), .sys_rst(SYS_RST), .arm(arm), .delay(dly), .irq_valid(IRQ_VALID),
        .irq_index(IRQ_INDEX), .isr_ack(ISR_ACK));
    task automatic cyc(int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(bit x, logic [15:0] a, logic [7:0] d);
        cyc(1);
        {XD_ADDR, XD_WDATA, XD_WE} = x ? {a, d, 1'b1} : {XD_ADDR, XD_WDATA, 1'b0};
        {SFR_ADDR, SFR_WDATA, SFR_WE} = x ? {SFR_ADDR, SFR_WDATA, 1'b0} : {a[7:0], d, 1'b1};
        cyc(1);
        {XD_WE, SFR_WE} = 2'b00;
    endtask
    task automatic rd(bit x, logic [15:0] a, logic [7:0] e);
        cyc(1);
        if (x) XD_ADDR = a;
        else SFR_ADDR = a[7:0];
        cyc(1);
        chk(x ? XD_RDATA : SFR_RDATA, e);
    endtask
    task automatic stop_test();
        if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        stop_test();
    end
    initial begin
        {SFR_WE, XD_WE, TMR0_OVF, TMR1_OVF, SER0_REQ, SER1_REQ, CE_BUSY, EEPROM_BUSY, PLL_LOCKED, arm} = '0;
        {DIO_HIGH_N, DIO_LOW_N, SYS_RST, sev, dly, SFR_ADDR, SFR_WDATA, XD_ADDR, XD_WDATA} = {3'b111, 52'h0};
        cyc(5);
        SYS_RST = 1'b0;
        for (i = 0; i < 8; i++) rd(0, ra[i], REG_RESET);
        for (i = 0; i < 8; i++) begin
            wr(0, ra[i], 8'hff);
            rd(0, ra[i], rm[i]);
        end
        // enables stay all ones so every sub-source but wake and button routes through
        for (i = 0; i < 4; i++) begin
            wr(1, xa[i], 8'hff);
            rd(1, xa[i], xm[i]);
        end
        wr(0, OFS_SUB_FLAGS, 8'hff);
        rd(0, OFS_SUB_FLAGS, 8'h00);
        wr(0, 8'h80, 8'hff);
        rd(0, 8'h80, 8'h00);
        for (i = 0; i < 8; i++) wr(0, ra[i], 8'h00);
        for (i = 0; i < 6; i++) begin
            sev[i] = 1'b1;
            cyc(1);
            sev[i] = 1'b0;
            rd(0, OFS_SUB_FLAGS, 8'((16'h2 << i) - 1));
        end
        PLL_LOCKED = 1'b1;
        cyc(1);
        PLL_LOCKED = 1'b0;
        rd(0, OFS_SUB_FLAGS, 8'hff);
        sev[7:6] = 2'b11;
        cyc(1);
        sev[7:6] = 2'b00;
        rd(1, OFS_WD_SPI_FLAG, 8'h11);
        CE_BUSY = 1'b1;
        EEPROM_BUSY = 1'b1;
        cyc(1);
        CE_BUSY = 1'b0;
        EEPROM_BUSY = 1'b0;
        rd(0, OFS_REQ_FLAGS, 8'h3e);
        chk(IRQ_VALID, 1'b0);
        wr(0, OFS_SUB_FLAGS, 8'hfe);
        rd(0, OFS_SUB_FLAGS, 8'hfe);
        wr(0, OFS_SUB_FLAGS, 8'hff);
        rd(0, OFS_SUB_FLAGS, 8'hfe);
        wr(0, OFS_SUB_FLAGS, 8'h00);
        wr(1, OFS_WD_SPI_FLAG, 8'h00);
        rd(1, OFS_WD_SPI_FLAG, 8'h00);
        wr(0, OFS_REQ_FLAGS, 8'h00);
        wr(0, OFS_ENABLE_1ST, 8'h0a);
        TMR0_OVF = 1'b1;
        cyc(1);
        TMR0_OVF = 1'b0;
        cyc(3);
        chk(IRQ_VALID, 1'b0);
        rd(0, OFS_TIMER_AND_EXT_IRQ_CONTROL_CTRL, 8'h20);
        wr(0, OFS_PRIO_LOW, 8'h08);
        wr(0, OFS_PRIO_HIGH, 8'h08);
        wr(0, OFS_ENABLE_1ST, 8'h8a);
        TMR1_OVF = 1'b1;
        cyc(1);
        TMR1_OVF = 1'b0;
        cyc(2);
        chk({IRQ_VALID, IRQ_INDEX, IRQ_LEVEL, IRQ_VECTOR}, {1'b1, 4'h6, 2'h3, 16'h001b});
        arm = 1'b1;
        cyc(12);
        rd(0, OFS_TIMER_AND_EXT_IRQ_CONTROL_CTRL, 8'h00);
        {arm, dly} = {1'b0, 4'h3};
        wr(0, OFS_PRIO_LOW, 8'h00);
        wr(0, OFS_PRIO_HIGH, 8'h00);
        {TMR0_OVF, TMR1_OVF} = 2'b11;
        cyc(1);
        {TMR0_OVF, TMR1_OVF} = 2'b00;
        cyc(2);
        chk({IRQ_VALID, IRQ_INDEX, IRQ_VECTOR}, {1'b1, 4'h2, 16'h000b});
        arm = 1'b1;
        cyc(20);
        rd(0, OFS_TIMER_AND_EXT_IRQ_CONTROL_CTRL, 8'h00);
        arm = 1'b0;
        wr(0, OFS_ENABLE_1ST, 8'h80);
        SER1_REQ = 1'b1;
        cyc(4);
        chk(IRQ_VALID, 1'b0);
        wr(0, OFS_ENABLE_3RD, 8'h01);
        cyc(3);
        chk({IRQ_VALID, IRQ_INDEX, IRQ_VECTOR}, {1'b1, 4'h1, 16'h0083});
        SER1_REQ = 1'b0;
        wr(0, OFS_ENABLE_1ST, 8'h90);
        SER0_REQ = 1'b1;
        cyc(3);
        chk({IRQ_VALID, IRQ_INDEX, IRQ_VECTOR}, {1'b1, 4'h8, 16'h0023});
        SER0_REQ = 1'b0;
        wr(0, OFS_TIMER_AND_EXT_IRQ_CONTROL_CTRL, 8'h01);
        wr(0, OFS_ENABLE_1ST, 8'h81);
        DIO_HIGH_N = 1'b0;
        cyc(3);
        chk({IRQ_VALID, IRQ_INDEX, IRQ_VECTOR}, {1'b1, 4'h0, 16'h0003});
        arm = 1'b1;
        cyc(8);
        rd(0, OFS_TIMER_AND_EXT_IRQ_CONTROL_CTRL, 8'h01);
        DIO_HIGH_N = 1'b1;
        // level mode: flag survives acknowledge while the line stays low
        arm = 1'b0;
        wr(0, OFS_TIMER_AND_EXT_IRQ_CONTROL_CTRL, 8'h00);
        wr(0, OFS_ENABLE_1ST, 8'h84);
        DIO_LOW_N = 1'b0;
        cyc(3);
        chk({IRQ_VALID, IRQ_INDEX, IRQ_VECTOR}, {1'b1, 4'h4, 16'h0013});
        arm = 1'b1;
        cyc(8);
        rd(0, OFS_TIMER_AND_EXT_IRQ_CONTROL_CTRL, 8'h08);
        DIO_LOW_N = 1'b1;
        cyc(8);
        rd(0, OFS_TIMER_AND_EXT_IRQ_CONTROL_CTRL, 8'h00);
        wr(0, OFS_T2_CTRL, 8'h60);
        CE_BUSY = 1'b1;
        cyc(1);
        rd(0, OFS_REQ_FLAGS, 8'h04);
        CE_BUSY = 1'b0;
        stop_test();
    end
endmodule
